//--- verilog/aobs_map.svh
// register map, field positions and reset values of the burst sequencer
`ifndef AOBS_MAP_SVH
`define AOBS_MAP_SVH

`define AOBS_BCR_OFFS 8'h00
`define AOBS_BOR_OFFS 8'h04
`define AOBS_RATE_B_OFFS 8'h08
`define AOBS_RATE_C_OFFS 8'h0C
`define AOBS_DATA_OFFS 8'h10
`define AOBS_STAT_OFFS 8'h14

`define AOBS_BCR_SIMUL 0
`define AOBS_BCR_TRIG_INT 1
`define AOBS_BCR_RATE_B_EN 2
`define AOBS_BCR_RATE_C_EN 3
`define AOBS_BCR_NACT_LSB 4
`define AOBS_BCR_NACT_MSB 5

`define AOBS_BOR_CLEAR 0
`define AOBS_BOR_CIRC 1
`define AOBS_BOR_CLK_INT 2
`define AOBS_BOR_CLK_EN 3
`define AOBS_BOR_BURST_EN 4
`define AOBS_BOR_SOFT_TRIG 5

`define AOBS_DATA_EOF 16

`define AOBS_STAT_EMPTY 9
`define AOBS_STAT_FULL 10
`define AOBS_STAT_BUSY 11

`define AOBS_BCR_RST 6'h30
`define AOBS_BOR_RST 6'h00
`define AOBS_RATE_RST 16'h0063
`define AOBS_DEPTH 9'h100

`endif

//--- verilog/aobs_pkg.sv
// types shared by the burst sequencer files
package aobs_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_FETCH = 2'b11,
        ST_LATCH = 2'b10
    } play_state_e;

    typedef struct packed {
        logic eof;
        logic [15:0] value;
    } buf_word_s;

    typedef struct packed {
        logic [8:0] head;
        logic [8:0] rd;
        logic [8:0] wr;
    } buf_ptrs_s;

    typedef logic [3:0][15:0] dac_group_t;

endpackage

//--- verilog/aobs_buffer_mem.sv
// output data buffer storage, registered read port
`timescale 1ns/1ps
`default_nettype none

module aobs_buffer_mem (
    input wire logic aclk,
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire aobs_pkg::buf_word_s wdata,
    input wire logic [7:0] raddr,
    output aobs_pkg::buf_word_s rdata
);
    aobs_pkg::buf_word_s mem [0:255];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule // aobs_buffer_mem

`default_nettype wire

//--- verilog/aobs_rate_gen.sv
// programmable rate generator, one tick per div+1 clocks
`timescale 1ns/1ps
`default_nettype none

module aobs_rate_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic en,
    input wire logic [15:0] div,
    output logic tick
);
    logic [15:0] count;
    logic [15:0] next_count;
    logic next_tick;

    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!en) begin
            next_count = div;
        end else if (count == 16'h0000) begin
            next_count = div;
            next_tick = 1'b1;
        end else begin
            next_count = count - 16'h0001;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 16'h0000;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    AST_RATE_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn)
        !en |=> !tick) else $error("rate generator ticked while disabled");
    AST_RATE_SPACING: assert property (@(posedge aclk) disable iff (!aresetn)
        (tick && en && div != 16'h0000 && $stable(div)) |=> !tick)
        else $error("rate generator ticked twice in a row");
endmodule // aobs_rate_gen

`default_nettype wire

//--- verilog/analog_output_burst_sequencer.sv
// triggered-burst playback of stored analog output functions, AXI4-Lite registers
`include "aobs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module analog_output_burst_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ext_clk,
    input wire logic ext_trig,
    output aobs_pkg::dac_group_t dac_value,
    output logic [3:0] dac_load,
    output logic burst_active
);
    logic [1:0] pin_s1, pin_s2, pin_s3;
    logic ext_clk_rise, ext_trig_rise;
    logic aw_got, w_got, next_aw_got, next_w_got;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic do_write, push, wr_mapped, rd_mapped;
    logic [31:0] rd_mux;
    logic [5:0] board_ctrl_reg, next_bcr, bor, next_bor;
    logic [15:0] rate_b, next_rate_b, rate_c, next_rate_c;
    logic rate_b_tick, rate_c_tick, trigger, sample_tick, clr, circ, empty, full;
    logic [8:0] level, adv;
    logic [1:0] n_act;
    aobs_pkg::play_state_e state, next_state;
    aobs_pkg::buf_ptrs_s ptrs, next_ptrs;
    aobs_pkg::buf_word_s rd_word, wr_word;
    aobs_pkg::dac_group_t hold, next_hold, next_dac_value;
    logic [3:0] next_dac_load;
    logic [1:0] ch, next_ch;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // external clock and trigger pins, two flops then edge detect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_s3 <= 2'h0;
        end else begin
            pin_s1 <= {ext_clk, ext_trig};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    assign ext_clk_rise = pin_s2[1] & ~pin_s3[1];
    assign ext_trig_rise = pin_s2[0] & ~pin_s3[0];

    // bus slave
    assign do_write = aw_got & w_got & ~bvalid;
    assign wr_mapped = aw_addr <= `AOBS_STAT_OFFS && aw_addr[1:0] == 2'b00;
    assign rd_mapped = araddr <= `AOBS_STAT_OFFS && araddr[1:0] == 2'b00;

    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (araddr)
            `AOBS_BCR_OFFS: rd_mux[5:0] = board_ctrl_reg;
            `AOBS_BOR_OFFS: rd_mux[5:0] = bor;
            `AOBS_RATE_B_OFFS: rd_mux[15:0] = rate_b;
            `AOBS_RATE_C_OFFS: rd_mux[15:0] = rate_c;
            `AOBS_STAT_OFFS: begin
                rd_mux[8:0] = level;
                rd_mux[`AOBS_STAT_EMPTY] = empty;
                rd_mux[`AOBS_STAT_FULL] = full;
                rd_mux[`AOBS_STAT_BUSY] = burst_active;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready) begin
            next_aw_got = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_got = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bvalid && bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = wr_mapped ? 2'b00 : 2'b10;
        end
        if (rvalid && rready) begin
            next_rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rdata = rd_mux;
            next_rresp = rd_mapped ? 2'b00 : 2'b10;
        end
        next_awready = ~next_aw_got & ~next_bvalid;
        next_wready = ~next_w_got & ~next_bvalid;
        next_arready = ~next_rvalid;
    end

    // control registers; clear and software trigger self-clear after one cycle
    always_comb begin
        next_bcr = board_ctrl_reg;
        next_bor = bor;
        next_rate_b = rate_b;
        next_rate_c = rate_c;
        next_bor[`AOBS_BOR_CLEAR] = 1'b0;
        next_bor[`AOBS_BOR_SOFT_TRIG] = 1'b0;
        if (do_write) begin
            unique case (aw_addr)
                `AOBS_BCR_OFFS: next_bcr = 6'(merge({26'h0, board_ctrl_reg}, w_data, w_strb));
                `AOBS_BOR_OFFS: next_bor = 6'(merge({26'h0, bor}, w_data, w_strb));
                `AOBS_RATE_B_OFFS: next_rate_b = 16'(merge({16'h0, rate_b}, w_data, w_strb));
                `AOBS_RATE_C_OFFS: next_rate_c = 16'(merge({16'h0, rate_c}, w_data, w_strb));
                default: next_bcr = board_ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= 2'h0;
            board_ctrl_reg <= `AOBS_BCR_RST;
            bor <= `AOBS_BOR_RST;
            rate_b <= `AOBS_RATE_RST;
            rate_c <= `AOBS_RATE_RST;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            board_ctrl_reg <= next_bcr;
            bor <= next_bor;
            rate_b <= next_rate_b;
            rate_c <= next_rate_c;
        end
    end

    aobs_rate_gen u_rate_b (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(board_ctrl_reg[`AOBS_BCR_RATE_B_EN]),
        .div(rate_b),
        .tick(rate_b_tick)
    );

    aobs_rate_gen u_rate_c (
        .aclk(aclk),
        .aresetn(aresetn),
        .en(board_ctrl_reg[`AOBS_BCR_RATE_C_EN]),
        .div(rate_c),
        .tick(rate_c_tick)
    );

    // trigger source, burst mode, software trigger, hardware trigger
    assign trigger = bor[`AOBS_BOR_BURST_EN] & (bor[`AOBS_BOR_SOFT_TRIG] |
        (board_ctrl_reg[`AOBS_BCR_TRIG_INT] ? rate_b_tick : ext_trig_rise));
    assign sample_tick = bor[`AOBS_BOR_CLK_EN] & (bor[`AOBS_BOR_CLK_INT] ? rate_c_tick : ext_clk_rise);

    assign clr = bor[`AOBS_BOR_CLEAR];
    assign circ = bor[`AOBS_BOR_CIRC];
    assign n_act = board_ctrl_reg[`AOBS_BCR_NACT_MSB:`AOBS_BCR_NACT_LSB];
    assign level = ptrs.wr - ptrs.head;
    assign empty = level == 9'h000;
    assign full = level == `AOBS_DEPTH;
    assign push = do_write & (aw_addr == `AOBS_DATA_OFFS) & ~full & ~circ;
    assign wr_word = '{eof: w_data[`AOBS_DATA_EOF], value: w_data[15:0]};

    aobs_buffer_mem u_mem (
        .aclk(aclk),
        .we(push),
        .waddr(ptrs.wr[7:0]),
        .wdata(wr_word),
        .raddr(ptrs.rd[7:0]),
        .rdata(rd_word)
    );

    // playback
    always_comb begin
        next_state = state;
        next_ptrs = ptrs;
        next_ch = ch;
        next_hold = hold;
        next_dac_value = dac_value;
        next_dac_load = 4'h0;
        adv = ptrs.rd + 9'h001;
        if (push) begin
            next_ptrs.wr = ptrs.wr + 9'h001;
        end
        unique case (state)
            aobs_pkg::ST_IDLE: begin
                next_ch = 2'h0;
                if (trigger && !empty) begin
                    next_state = aobs_pkg::ST_ARMED;
                end
            end
            aobs_pkg::ST_ARMED: begin
                if (sample_tick) begin
                    next_state = aobs_pkg::ST_FETCH;
                end
            end
            aobs_pkg::ST_FETCH: begin
                if (ptrs.rd == ptrs.wr) begin
                    next_state = aobs_pkg::ST_IDLE;
                end else begin
                    // circular wraps to oldest entry and keeps it
                    if (circ && adv == ptrs.wr) begin
                        adv = ptrs.head;
                    end
                    next_ptrs.rd = adv;
                    if (!circ) begin
                        next_ptrs.head = adv;
                    end
                    next_state = aobs_pkg::ST_LATCH;
                end
            end
            aobs_pkg::ST_LATCH: begin
                next_hold[ch] = rd_word.value;
                if (!board_ctrl_reg[`AOBS_BCR_SIMUL]) begin
                    next_dac_value[ch] = rd_word.value;
                    next_dac_load[ch] = 1'b1;
                end
                if (ch == n_act || rd_word.eof) begin
                    if (board_ctrl_reg[`AOBS_BCR_SIMUL]) begin
                        next_dac_value = next_hold;
                        for (int i = 0; i < 4; i++) begin
                            next_dac_load[i] = 3'(i) <= {1'b0, n_act};
                        end
                    end
                    next_ch = 2'h0;
                    next_state = rd_word.eof ? aobs_pkg::ST_IDLE : aobs_pkg::ST_ARMED;
                end else begin
                    next_ch = ch + 2'h1;
                    next_state = aobs_pkg::ST_FETCH;
                end
            end
        endcase
        if (clr) begin
            next_ptrs = '0;
            next_state = aobs_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= aobs_pkg::ST_IDLE;
            ptrs <= '0;
            ch <= 2'h0;
            hold <= '0;
            dac_value <= '0;
            dac_load <= 4'h0;
            burst_active <= 1'b0;
        end else begin
            state <= next_state;
            ptrs <= next_ptrs;
            ch <= next_ch;
            hold <= next_hold;
            dac_value <= next_dac_value;
            dac_load <= next_dac_load;
            burst_active <= next_state != aobs_pkg::ST_IDLE;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_CLEAR_EMPTIES: assert property (clr |=> empty && state == aobs_pkg::ST_IDLE)
        else $error("clear did not empty buffer");
    AST_WRITE_APPENDS: assert property (push && !clr |=> ptrs.wr == $past(ptrs.wr) + 9'h001)
        else $error("buffer write not appended");
    AST_EOF_ENDS: assert property ((state == aobs_pkg::ST_LATCH && rd_word.eof && !clr)
        |=> state == aobs_pkg::ST_IDLE && !burst_active) else $error("flag did not end burst");
    AST_EXT_TRIG: assert property ((state == aobs_pkg::ST_IDLE && !board_ctrl_reg[`AOBS_BCR_TRIG_INT]
        && !bor[`AOBS_BOR_SOFT_TRIG] && !ext_trig_rise && !clr) |=> state == aobs_pkg::ST_IDLE)
        else $error("burst began without external trigger");
    AST_INT_TRIG: assert property ((state == aobs_pkg::ST_IDLE && board_ctrl_reg[`AOBS_BCR_TRIG_INT]
        && bor[`AOBS_BOR_BURST_EN] && rate_b_tick && !empty && !clr)
        |=> state == aobs_pkg::ST_ARMED) else $error("internal trigger missed");
    AST_NO_MODE: assert property ((!bor[`AOBS_BOR_BURST_EN] && state == aobs_pkg::ST_IDLE)
        |=> state == aobs_pkg::ST_IDLE) else $error("burst outside burst mode");
    AST_CIRC_KEEPS: assert property ((circ && !clr && !push) |=> level == $past(level))
        else $error("closed buffer lost entries");
    AST_INT_CLOCK: assert property ((state == aobs_pkg::ST_ARMED && bor[`AOBS_BOR_CLK_EN]
        && bor[`AOBS_BOR_CLK_INT] && rate_c_tick && !clr) |=> state == aobs_pkg::ST_FETCH)
        else $error("internal sample clock missed");
    AST_CLK_GATED: assert property ((state == aobs_pkg::ST_ARMED && !bor[`AOBS_BOR_CLK_EN]
        && !clr) |=> state == aobs_pkg::ST_ARMED) else $error("group output while clocking off");
    AST_SOFT_ONE: assert property ((state == aobs_pkg::ST_IDLE && bor[`AOBS_BOR_SOFT_TRIG]
        && bor[`AOBS_BOR_BURST_EN] && !empty && !clr) |=> state == aobs_pkg::ST_ARMED)
        else $error("software trigger missed");
    AST_EXT_ONE: assert property ((state == aobs_pkg::ST_IDLE && ext_trig_rise
        && !board_ctrl_reg[`AOBS_BCR_TRIG_INT] && bor[`AOBS_BOR_BURST_EN] && !empty && !clr)
        |=> state == aobs_pkg::ST_ARMED) else $error("external trigger missed");

    COV_SOFT_BURST: cover property (bor[`AOBS_BOR_SOFT_TRIG] ##[1:60] dac_load != 4'h0);
    COV_CIRC_BURST: cover property (circ && state == aobs_pkg::ST_LATCH && rd_word.eof);
    COV_EXT_CLOCK: cover property (ext_clk_rise && state == aobs_pkg::ST_ARMED);
    COV_FULL: cover property (full);
endmodule // analog_output_burst_sequencer

`default_nettype wire

//--- bench/testbench.sv
// self-checking bench for the analog output burst sequencer
`timescale 1ns/1ps
`default_nettype none
`include "aobs_map.svh"

module testbench;
    localparam logic [1:0] OKAY = 2'b00;
    localparam logic [1:0] SLVERR = 2'b10;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic [7:0] araddr;
    logic awvalid, wvalid, bready, arvalid, rready, ext_clk, ext_trig;
    logic awready, wready, bvalid, arready, rvalid, burst_active;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic [3:0] wstrb;
    logic [3:0] dac_load;
    logic [1:0] bresp;
    logic [1:0] rresp;
    aobs_pkg::dac_group_t dac_value;
    logic [15:0] seen[$];
    int miscompares;
    int comparisons;
    int joint;

    analog_output_burst_sequencer dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_clk(ext_clk),
        .ext_trig(ext_trig), .dac_value(dac_value), .dac_load(dac_load), .burst_active(burst_active)
    );

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // records every channel update in order, sampled mid-cycle where settled
    always @(negedge aclk) begin
        if ($countones(dac_load) > 1) begin
            joint++;
        end
        for (int i = 0; i < 4; i++) begin
            if (dac_load[i] === 1'b1) begin
                seen.push_back(dac_value[i]);
            end
        end
    end

    task automatic close_out();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic timeout(input string what);
        chk(what, 32'h0000_0000, 32'h0000_0001);
        close_out();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (aw_done && w_done && bvalid === 1'b1) begin
                chk("bresp", 32'(er), 32'(bresp));
                return;
            end
            if (awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        timeout("write wait");
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic a_done;
        a_done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (a_done && rvalid === 1'b1) begin
                chk("rdata", exp, rdata);
                chk("rresp", 32'(er), 32'(rresp));
                return;
            end
            if (arready === 1'b1) begin
                a_done = 1'b1;
                arvalid <= 1'b0;
            end
        end
        timeout("read wait");
    endtask

    task automatic load(input logic [31:0] ws[$]);
        foreach (ws[i]) begin
            wr(`AOBS_DATA_OFFS, ws[i], OKAY);
        end
    endtask

    task automatic wait_active(input logic v);
        for (int i = 0; i < 1000; i++) begin
            @(posedge aclk);
            if (burst_active === v) begin
                return;
            end
        end
        timeout("burst_active wait");
    endtask

    task automatic chk_seen(input logic [15:0] exp[$], input int nj);
        chk("update count", 32'(exp.size()), 32'(seen.size()));
        chk("joint loads", 32'(nj), 32'(joint));
        foreach (exp[i]) begin
            if (i < seen.size()) begin
                chk("dac value", 32'(exp[i]), 32'(seen[i]));
            end
        end
        seen.delete();
        joint = 0;
    endtask

    task automatic ext_clks(input int n);
        repeat (n) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge aclk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge aclk);
        end
    endtask

    initial begin
        aresetn = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        awvalid = 1'b0;
        wvalid = 1'b0;
        arvalid = 1'b0;
        bready = 1'b1;
        rready = 1'b1;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        ext_clk = 1'b0;
        ext_trig = 1'b0;
        miscompares = 0;
        comparisons = 0;
        joint = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rchk(`AOBS_BCR_OFFS, 32'h0000_0030, OKAY);
        rchk(`AOBS_BOR_OFFS, 32'h0000_0000, OKAY);
        rchk(`AOBS_RATE_B_OFFS, 32'h0000_0063, OKAY);
        rchk(`AOBS_RATE_C_OFFS, 32'h0000_0063, OKAY);
        rchk(`AOBS_STAT_OFFS, 32'h0000_0200, OKAY);
        wr(8'h40, 32'h0000_0001, SLVERR);
        rchk(8'h40, 32'h0000_0000, SLVERR);
        // two active channels, simultaneous updates
        wr(`AOBS_BCR_OFFS, 32'h0000_0011, OKAY);
        load('{32'h0000_1111, 32'h0000_2222, 32'h0000_3333, 32'h0001_4444});
        load('{32'h0000_5555, 32'h0001_6666});
        rchk(`AOBS_STAT_OFFS, 32'h0000_0006, OKAY);
        wr(`AOBS_BOR_OFFS, 32'h0000_0001, OKAY);
        rchk(`AOBS_STAT_OFFS, 32'h0000_0200, OKAY);
        load('{32'h0000_1111, 32'h0000_2222, 32'h0000_3333, 32'h0001_4444});
        load('{32'h0000_5555, 32'h0001_6666});
        wr(`AOBS_RATE_C_OFFS, 32'h0000_0003, OKAY);
        wr(`AOBS_BCR_OFFS, 32'h0000_0019, OKAY);
        wr(`AOBS_BOR_OFFS, 32'h0000_001c, OKAY);
        chk("idle outputs", 32'h0000_0000, 32'(seen.size()));
        wr(`AOBS_BOR_OFFS, 32'h0000_003c, OKAY);
        wait_active(1'b1);
        wait_active(1'b0);
        chk_seen('{16'h1111, 16'h2222, 16'h3333, 16'h4444}, 2);
        rchk(`AOBS_BOR_OFFS, 32'h0000_001c, OKAY);
        wr(`AOBS_BOR_OFFS, 32'h0000_003c, OKAY);
        wait_active(1'b1);
        wait_active(1'b0);
        chk_seen('{16'h5555, 16'h6666}, 1);
        rchk(`AOBS_STAT_OFFS, 32'h0000_0200, OKAY);
        // circular buffer replayed by the trigger rate generator
        wr(`AOBS_BOR_OFFS, 32'h0000_0001, OKAY);
        load('{32'h0000_0a0a, 32'h0001_0b0b});
        wr(`AOBS_BOR_OFFS, 32'h0000_001e, OKAY);
        load('{32'h0000_0c0c});
        rchk(`AOBS_STAT_OFFS, 32'h0000_0002, OKAY);
        wr(`AOBS_BCR_OFFS, 32'h0000_001f, OKAY);
        repeat (250) @(posedge aclk);
        wr(`AOBS_BCR_OFFS, 32'h0000_0019, OKAY);
        wait_active(1'b0);
        chk("trigger bursts", 32'h0000_0004, 32'(seen.size()));
        chk("joint loads", 32'h0000_0002, 32'(joint));
        foreach (seen[i]) begin
            chk("replayed value", (i % 2) ? 32'h0000_0b0b : 32'h0000_0a0a, 32'(seen[i]));
        end
        seen.delete();
        joint = 0;
        // external trigger and clock, clocking held off first
        wr(`AOBS_BCR_OFFS, 32'h0000_0011, OKAY);
        wr(`AOBS_BOR_OFFS, 32'h0000_0012, OKAY);
        ext_trig <= 1'b1;
        repeat (4) @(posedge aclk);
        ext_trig <= 1'b0;
        wait_active(1'b1);
        ext_clks(4);
        chk("clocking off", 32'h0000_0000, 32'(seen.size()));
        wr(`AOBS_BOR_OFFS, 32'h0000_001a, OKAY);
        ext_clks(4);
        wait_active(1'b0);
        chk_seen('{16'h0a0a, 16'h0b0b}, 1);
        // per-channel updates with simultaneous outputs off
        wr(`AOBS_BCR_OFFS, 32'h0000_0018, OKAY);
        wr(`AOBS_BOR_OFFS, 32'h0000_003e, OKAY);
        wait_active(1'b1);
        wait_active(1'b0);
        chk_seen('{16'h0a0a, 16'h0b0b}, 0);
        close_out();
    end
endmodule // testbench

`default_nettype wire
